// *** hdl/eil_pkg.sv ***
package eil_pkg;

  // register byte offsets
  localparam logic [11:0] STATUS_CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFFSET     = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFFSET       = 12'h008;
  localparam logic [11:0] PIN_LEVEL_OFFSET      = 12'h00C;

  // fields of the status/control register
  localparam int SENSE_BIT   = 0;
  localparam int MASK_BIT    = 1;
  localparam int ACK_BIT     = 2;
  localparam int PENDING_BIT = 3;

  // sticky event bits
  localparam int EV_LATCH_BIT = 0;
  localparam int EV_FALL_BIT  = 1;
  localparam int EV_WIDTH     = 2;

  // fixed vector locations taken for this request
  localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFFA;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFFB;

  localparam logic [31:0] SLAVE_ERROR_READ = 32'h0000_0000;

  // data handed from the pin conditioner to the latch logic
  typedef struct packed {
    logic level;
    logic fall;
  } eil_pin_t;

endpackage

// *** hdl/eil_pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser and falling edge detection on the request pin
module eil_pin_sync
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             pin_n,
  output eil_pkg::eil_pin_t     pin_out
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // idle pin level is high (pulled up), so reset to one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= pin_n;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign pin_out.level = sync_reg;
  assign pin_out.fall  = prev_reg & ~sync_reg;

endmodule
`default_nettype wire

// *** hdl/eil_irq_latch.sv ***
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module eil_irq_latch
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin_n,
  input  wire logic        vector_fetch_ack,
  input  wire logic        condition_code_reg_imask,
  output logic             cpu_irq_req,
  output logic      [15:0] cpu_vector_addr,
  output logic             branch_pin_level,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  // pin conditioning

  eil_pkg::eil_pin_t pin;

  eil_pin_sync u_pin_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_n   (ext_irq_pin_n),
    .pin_out (pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  logic        irq_latch_reg;
  logic        irq_latch_next;
  logic        ack_seen_reg;
  logic        ack_seen_next;
  logic        irq_sense_select_reg;
  logic        irq_mask_bit_reg;
  logic [eil_pkg::EV_WIDTH-1:0] ev_status_reg;
  logic [eil_pkg::EV_WIDTH-1:0] ev_status_next;
  logic [eil_pkg::EV_WIDTH-1:0] ev_mask_reg;

  wire         access   = psel & penable;
  wire         wr_en    = access & pwrite & pstrb[0];
  wire         sel_sc   = hit(paddr, eil_pkg::STATUS_CONTROL_OFFSET);
  wire         sel_st   = hit(paddr, eil_pkg::IRQ_STATUS_OFFSET);
  wire         sel_mk   = hit(paddr, eil_pkg::IRQ_MASK_OFFSET);
  wire         sel_pl   = hit(paddr, eil_pkg::PIN_LEVEL_OFFSET);
  wire         mapped   = sel_sc | sel_st | sel_mk | sel_pl;
  wire         wr_sc    = wr_en & sel_sc;
  wire         sw_ack   = wr_sc & pwdata[eil_pkg::ACK_BIT];
  wire         any_ack  = sw_ack | vector_fetch_ack;

  //////////////////////////////////////////////////////////////////////////////
  // request latch

  // set term: edge always, low level only in level mode
  wire set_req = pin.fall | (irq_sense_select_reg & ~pin.level);

  always_comb
  begin
    irq_latch_next = irq_latch_reg;
    ack_seen_next  = ack_seen_reg;
    if (!irq_sense_select_reg)
    begin
      // edge mode: acknowledge clears immediately; a new edge wins
      ack_seen_next = 1'b0;
      if (any_ack)
        irq_latch_next = 1'b0;
      if (pin.fall)
        irq_latch_next = 1'b1;
    end
    else
    begin
      // level mode: remember the acknowledge until the pin returns high
      if (any_ack && irq_latch_reg)
        ack_seen_next = 1'b1;
      if ((ack_seen_reg || any_ack) && pin.level && irq_latch_reg)
      begin
        irq_latch_next = 1'b0;
        ack_seen_next  = 1'b0;
      end
      if (set_req)
        irq_latch_next = 1'b1;
      if (pin.fall)
        ack_seen_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_latch_reg <= 1'b0;
      ack_seen_reg  <= 1'b0;
    end
    else
    begin
      irq_latch_reg <= irq_latch_next;
      ack_seen_reg  <= ack_seen_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control bits

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_sense_select_reg <= 1'b0;
      irq_mask_bit_reg     <= 1'b0;
    end
    else if (wr_sc)
    begin
      irq_sense_select_reg <= pwdata[eil_pkg::SENSE_BIT];
      irq_mask_bit_reg     <= pwdata[eil_pkg::MASK_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky event status, write one to clear; a new event wins over the clear

  wire [eil_pkg::EV_WIDTH-1:0] ev_set = {pin.fall, irq_latch_next & ~irq_latch_reg};
  wire [eil_pkg::EV_WIDTH-1:0] ev_clr =
    (wr_en & sel_st) ? pwdata[eil_pkg::EV_WIDTH-1:0] : '0;

  assign ev_status_next = (ev_status_reg & ~ev_clr) | ev_set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_status_reg <= '0;
      ev_mask_reg   <= '0;
    end
    else
    begin
      ev_status_reg <= ev_status_next;
      if (wr_en && sel_mk)
        ev_mask_reg <= pwdata[eil_pkg::EV_WIDTH-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  wire [31:0] sc_rd = {28'h0000000, irq_latch_reg, 1'b0, irq_mask_bit_reg,
                       irq_sense_select_reg};
  wire [31:0] rd_mux =
    sel_sc ? sc_rd :
    sel_st ? {30'h0, ev_status_reg} :
    sel_mk ? {30'h0, ev_mask_reg} :
    sel_pl ? {31'h0, pin.level} :
             eil_pkg::SLAVE_ERROR_READ;

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs

  wire req_next = irq_latch_next & ~irq_mask_bit_reg & ~condition_code_reg_imask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata           <= '0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      cpu_irq_req      <= 1'b0;
      cpu_vector_addr  <= eil_pkg::VECTOR_HI_ADDR;
      branch_pin_level <= 1'b1;
      irq              <= 1'b0;
    end
    else
    begin
      // no wait state: setup, then ready in the first access cycle
      pready           <= psel & ~penable;
      pslverr          <= psel & ~penable & ~mapped;
      prdata           <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
      cpu_irq_req      <= req_next;
      cpu_vector_addr  <= vector_fetch_ack ? eil_pkg::VECTOR_LO_ADDR : eil_pkg::VECTOR_HI_ADDR;
      branch_pin_level <= pin.level;
      irq              <= |(ev_status_next & ev_mask_reg);
    end
  end

endmodule
`default_nettype wire

// *** sim/eil_pin_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module eil_pin_model
(
  input  wire logic hold_low,
  output logic      ext_irq_pin_n
);
  // a released pin floats up to the pull-up level
  assign ext_irq_pin_n = hold_low ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// *** sim/eil_irq_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module eil_irq_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_irq_pin_n,
  input wire logic        vector_fetch_ack,
  input wire logic        condition_code_reg_imask,
  input wire logic        cpu_irq_req,
  input wire logic [15:0] cpu_vector_addr,
  input wire logic        branch_pin_level,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic unmapped = (paddr > 12'h00C) || (paddr[1:0] != 2'h0);
  wire logic sc_read = pready && !pwrite && (paddr == eil_pkg::STATUS_CONTROL_OFFSET);
  ////////////////////////////////////////////////////////////////
  answer_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  error_decode_a: assert property (pready |-> pslverr == unmapped)
    else $error("wrong slave error");
  error_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  ack_reads_zero_a: assert property (sc_read |-> prdata[31:4] == 28'h0 && !prdata[eil_pkg::ACK_BIT])
    else $error("ack or spare bits read one");
  global_mask_a: assert property (condition_code_reg_imask |=> !cpu_irq_req)
    else $error("request passed global mask");
  vector_low_a: assert property (vector_fetch_ack |=> cpu_vector_addr == eil_pkg::VECTOR_LO_ADDR)
    else $error("second vector byte missed");
  vector_high_a: assert property (!vector_fetch_ack |=> cpu_vector_addr == eil_pkg::VECTOR_HI_ADDR)
    else $error("first vector byte missed");
  pin_level_a: assert property ($stable(ext_irq_pin_n) [*4] |-> branch_pin_level == ext_irq_pin_n)
    else $error("pin level not offered");
  req_seen_c: cover property (cpu_irq_req);
  irq_seen_c: cover property (irq);
  error_seen_c: cover property (pslverr);
endmodule
bind eil_irq_latch eil_irq_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_irq_pin_n(ext_irq_pin_n), .vector_fetch_ack(vector_fetch_ack),
  .condition_code_reg_imask(condition_code_reg_imask), .cpu_irq_req(cpu_irq_req),
  .cpu_vector_addr(cpu_vector_addr), .branch_pin_level(branch_pin_level), .irq(irq));
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic        vfa = 1'b0;
  logic        gmask = 1'b0;
  logic        hold_low = 1'b0;
  logic [31:0] rd;
  logic        er;
  wire  [31:0] prdata;
  wire  [15:0] vec;
  wire         pready, pslverr, req, blev, irq, pin_n;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #25 pclk = ~pclk;
  eil_pin_model pm (.hold_low(hold_low), .ext_irq_pin_n(pin_n));
  eil_irq_latch dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin_n(pin_n), .vector_fetch_ack(vfa), .condition_code_reg_imask(gmask), .cpu_irq_req(req),
    .cpu_vector_addr(vec), .branch_pin_level(blev), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pin(input logic low);
    @(posedge pclk);
    hold_low <= low;
    repeat (5) @(posedge pclk);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h000, 32'h0);
    rdchk(12'h00C, 32'h1);
    xfer(1'b1, 12'h008, 32'h3);
    pin(1'b1);
    chk({31'h0, blev}, 32'h0);
    rdchk(12'h000, 32'h8);
    chk({31'h0, req}, 32'h1);
    rdchk(12'h004, 32'h3);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, 12'h004, 32'h3);
    rdchk(12'h004, 32'h0);
    chk({31'h0, irq}, 32'h0);
    gmask <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, req}, 32'h0);
    gmask <= 1'b0;
    xfer(1'b1, 12'h000, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, req}, 32'h0);
    rdchk(12'h000, 32'hA);
    pstrb <= 4'h0;
    xfer(1'b1, 12'h000, 32'h0);
    pstrb <= 4'hF;
    rdchk(12'h000, 32'hA);
    xfer(1'b1, 12'h000, 32'h4);
    rdchk(12'h000, 32'h0);
    pin(1'b0);
    pin(1'b1);
    rdchk(12'h000, 32'h8);
    vfa <= 1'b1;
    @(posedge pclk);
    vfa <= 1'b0;
    @(negedge pclk);
    chk({16'h0, vec}, 32'h0000FFFB);
    repeat (2) @(posedge pclk);
    rdchk(12'h000, 32'h0);
    pin(1'b0);
    xfer(1'b1, 12'h000, 32'h1);
    pin(1'b1);
    rdchk(12'h000, 32'h9);
    xfer(1'b1, 12'h000, 32'h5);
    rdchk(12'h000, 32'h9);
    pin(1'b0);
    rdchk(12'h000, 32'h1);
    pin(1'b1);
    pin(1'b0);
    rdchk(12'h000, 32'h9);
    xfer(1'b1, 12'h000, 32'h5);
    rdchk(12'h000, 32'h1);
    rdchk(12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    xfer(1'b1, 12'h000, 32'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h000, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
